// ===== src/uart_fmt_pkg.sv
// package: register map, field layout, codes and types of the uart irq/fifo/format block
package uart_fmt_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_DATA  = 8'h00;
  localparam logic [7:0] OFS_IER   = 8'h04;
  localparam logic [7:0] OFS_IDENT = 8'h08;
  localparam logic [7:0] OFS_FMT   = 8'h0C;
  localparam logic [7:0] OFS_LSR   = 8'h14;
  localparam logic [7:0] OFS_MSR   = 8'h18;
  // fifo_setup fields
  localparam int FS_ON   = 0;
  localparam int FS_RXFL = 1;
  localparam int FS_TXFL = 2;
  localparam int FS_TRIG = 6;
  // frame_format fields
  localparam int FF_DIV  = 7;
  localparam int FF_BRK  = 6;
  localparam int FF_PS   = 4;
  localparam int FF_PEN  = 3;
  localparam int FF_STOP = 2;
  localparam int FF_WL   = 0;
  // irq enable bits
  localparam int IE_RDA  = 0;
  localparam int IE_TX_HOLDING_EMPTY_IRQ = 1;
  localparam int IE_RLS  = 2;
  localparam int IE_MS   = 3;
  localparam int IE_TRANSMITTER_EMPTY_IRQ = 4;
  // identity codes, bit 0 is the pending flag (low = pending)
  localparam logic [3:0] ID_RLS  = 4'h6;
  localparam logic [3:0] ID_RDA  = 4'h4;
  localparam logic [3:0] ID_CTI  = 4'hC;
  localparam logic [3:0] ID_TX_HOLDING_EMPTY_IRQ = 4'h2;
  localparam logic [3:0] ID_TRANSMITTER_EMPTY_IRQ = 4'hE;
  localparam logic [3:0] ID_MS   = 4'h0;
  localparam logic [3:0] ID_NONE = 4'h1;
  // reset values
  localparam logic [7:0]  FMT_RST  = 8'h00;
  localparam logic [4:0]  IER_RST  = 5'h00;
  localparam logic [1:0]  TRIG_RST = 2'h0;
  localparam logic        ON_RST   = 1'b1;
  localparam logic [15:0] DIV_RST  = 16'h0000;
  // fifo geometry
  localparam int          DEPTH   = 16;
  localparam logic [4:0]  CNT_MAX = 5'h10;
  // baud ticks are 16x oversample ticks
  localparam logic [4:0]  BIT_TICKS  = 5'h10;
  localparam logic [4:0]  STOP15_TKS = 5'h18;
  localparam logic [4:0]  STOP2_TKS  = 5'h20;
  // timeout: 4 character times = frame bits * 16 ticks * 4
  localparam int          CTI_SHIFT  = 6;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parity;
    logic       frame_err;
    logic       brk;
  } rx_char_s;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } tx_state_e;
endpackage

// ===== src/uart_irq_fifo_line_format.sv
`timescale 1ns/1ps
// uart interrupt identification, fifo control and character frame format
//
// Contract
// [R1] line status irq, code 0110, highest; cleared by line status read
// [R2] data available irq, code 0100, when rx fill reaches trigger level
// [R3] char timeout irq, code 1100, after idle nonempty rx fifo; rb read clears
// [R4] thr empty 0010 and tx empty 1110, cleared by identity read or thr write
// [R5] modem change irq, code 0000, lowest; cleared by modem status read
// [R6] software decodes identity bits 3:0 and reads it before leaving isr
// [R7] fifo_setup bits 7:6 pick rx trigger of 1, 4, 8 or 14
// [R8] fifo_setup bit 2 flushes tx fifo pointers, self clearing
// [R9] fifo_setup bit 1 flushes rx fifo pointers, self clearing
// [R10] fifo_setup bit 0 resets to one, gates writes of bits 7:1
// [R11] frame_format bit 7 opens divisor latch at shared offsets
// [R12] frame_format bit 6 forces the serial output low
// [R13] parity select: odd, even, stuck one, stuck zero
// [R14] frame_format bit 3 enables parity generation and checking
// [R15] stop bits: one, or two, or one and a half for 5-bit words
// [R16] word length 5 to 8 bits for both directions
// [R17] identity bit 0 low while any enabled irq is pending
// [R18] sources frozen during identity read; new events reported next read
// [R19] data available enable gates data available and timeout irqs
// [R20] timeout character time follows baud ticks and configured frame length
module uart_irq_fifo_line_format (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic [7:0]            addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output      logic [31:0]           rdata,
  input  wire logic                  baud_tick,
  input  wire uart_fmt_pkg::rx_char_s rx_char,
  input  wire logic [3:0]            modem_lines,
  output      logic                  txd,
  output      logic                  irq,
  output      logic [15:0]           divisor
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // [R13] parity bit for a masked character
  function automatic logic par_calc(input logic [7:0] d, input logic [1:0] ps);
    case (ps)
      2'b00:   par_calc = ~(^d);
      2'b01:   par_calc = ^d;
      2'b10:   par_calc = 1'b1;
      default: par_calc = 1'b0;
    endcase
  endfunction

  // [R7] trigger level decode
  function automatic logic [4:0] trig_level(input logic [1:0] t);
    case (t)
      2'b00:   trig_level = 5'h01;
      2'b01:   trig_level = 5'h04;
      2'b10:   trig_level = 5'h08;
      default: trig_level = 5'h0E;
    endcase
  endfunction

  logic [7:0]              frame_r;
  logic [4:0]              ier_r;
  logic [1:0]              trig_r;
  logic                    fifo_on_r;
  logic [15:0]             div_r;
  logic [7:0]              rx_mem [uart_fmt_pkg::DEPTH];
  logic [7:0]              tx_mem [uart_fmt_pkg::DEPTH];
  logic [3:0]              rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
  logic [4:0]              rx_cnt_r, tx_cnt_r;
  logic [3:0]              err_r;
  logic [9:0]              cti_tmr_r;
  logic                    cti_r, tx_holding_empty_irq_r, transmitter_empty_irq_r, ms_r;
  logic                    tx_empty_d_r, transmitter_empty_irq_d_r;
  logic [3:0]              modem_d_r;
  uart_fmt_pkg::tx_state_e tx_state_r, tx_state_nxt;
  logic [4:0]              tx_tick_r, tx_tick_nxt;
  logic [7:0]              tx_sh_r, tx_sh_nxt;
  logic [2:0]              tx_bit_r, tx_bit_nxt;
  logic                    tx_par_r, tx_par_nxt;
  logic                    txd_r, irq_r;
  logic [31:0]             rdata_r;

  // decode
  wire       divisor_access_select     = frame_r[uart_fmt_pkg::FF_DIV];
  wire [1:0] wl       = frame_r[uart_fmt_pkg::FF_WL +: 2];
  wire [1:0] ps       = frame_r[uart_fmt_pkg::FF_PS +: 2];
  wire       pen      = frame_r[uart_fmt_pkg::FF_PEN];
  wire       stop_bit_select      = frame_r[uart_fmt_pkg::FF_STOP];
  wire       a_data   = hit(addr, uart_fmt_pkg::OFS_DATA);
  wire       a_ier    = hit(addr, uart_fmt_pkg::OFS_IER);
  wire       a_ident  = hit(addr, uart_fmt_pkg::OFS_IDENT);
  wire       a_fmt    = hit(addr, uart_fmt_pkg::OFS_FMT);
  wire       a_lsr    = hit(addr, uart_fmt_pkg::OFS_LSR);
  wire       a_msr    = hit(addr, uart_fmt_pkg::OFS_MSR);
  // [R11] divisor latch shares data/ier offsets
  wire       rb_rd    = rd_en && a_data && !divisor_access_select;
  wire       thr_wr   = wr_en && a_data && !divisor_access_select;
  wire       dll_wr   = wr_en && a_data && divisor_access_select;
  wire       dlm_wr   = wr_en && a_ier && divisor_access_select;
  wire       ier_wr   = wr_en && a_ier && !divisor_access_select;
  wire       id_rd    = rd_en && a_ident;
  wire       fs_wr    = wr_en && a_ident;
  wire       fmt_wr   = wr_en && a_fmt;
  wire       ls_rd    = rd_en && a_lsr;
  wire       ms_rd    = rd_en && a_msr;
  // [R10] bits 7:1 only take effect with bit 0 written as one
  wire       fs_ok    = fs_wr && wdata[uart_fmt_pkg::FS_ON];
  // [R8] tx flush pulse, nothing stored
  wire       tx_flush = fs_ok && wdata[uart_fmt_pkg::FS_TXFL];
  // [R9] rx flush pulse, nothing stored
  wire       rx_flush = fs_ok && wdata[uart_fmt_pkg::FS_RXFL];

  // [R16] mask to word length
  wire [7:0] wl_mask  = ~(8'(8'hE0 << wl));
  wire [7:0] rx_word  = rx_char.data & wl_mask;
  wire       rx_full  = rx_cnt_r == uart_fmt_pkg::CNT_MAX;
  wire       rx_push  = rx_char.valid && !rx_full && fifo_on_r;
  wire       rx_pop   = rb_rd && rx_cnt_r != 5'h00;
  // [R14] parity checked only when enabled
  wire       par_bad  = pen && (rx_char.parity != par_calc(rx_word, ps));
  wire [3:0] err_set  = {4{rx_char.valid}} &
                        {rx_char.brk, rx_char.frame_err, par_bad, rx_full};
  wire       tx_push  = thr_wr && tx_cnt_r != uart_fmt_pkg::CNT_MAX;
  wire       tx_pop   = tx_state_r == uart_fmt_pkg::TX_IDLE && tx_cnt_r != 5'h00;
  wire       tx_empty = tx_cnt_r == 5'h00;
  wire       tx_done  = tx_empty && tx_state_r == uart_fmt_pkg::TX_IDLE;

  // [R20] frame bits = start + data + parity + stop
  wire [3:0] fr_bits  = 4'(4'h7 + {2'b00, wl} + {3'b000, pen} + {3'b000, stop_bit_select});
  wire [9:0] cti_lim  = 10'({6'h00, fr_bits} << uart_fmt_pkg::CTI_SHIFT);
  wire       rx_act   = rx_push || rx_pop || rx_flush || rx_cnt_r == 5'h00;
  // [R3] timeout after about four idle character times
  wire       cti_set  = baud_tick && !rx_act && cti_tmr_r == 10'(cti_lim - 10'h001);

  // [R2] level from fill against trigger
  wire       rda_lvl  = fifo_on_r && rx_cnt_r >= trig_level(trig_r);
  // [R19] data enable gates both rx sources
  wire       p_rls    = ier_r[uart_fmt_pkg::IE_RLS] && err_r != 4'h0;
  wire       p_rda    = ier_r[uart_fmt_pkg::IE_RDA] && rda_lvl;
  wire       p_cti    = ier_r[uart_fmt_pkg::IE_RDA] && cti_r;
  wire       p_tx_holding_empty_irq   = ier_r[uart_fmt_pkg::IE_TX_HOLDING_EMPTY_IRQ] && tx_holding_empty_irq_r;
  wire       p_transmitter_empty_irq   = ier_r[uart_fmt_pkg::IE_TRANSMITTER_EMPTY_IRQ] && transmitter_empty_irq_r;
  wire       p_ms     = ier_r[uart_fmt_pkg::IE_MS] && ms_r;
  // [R1] priority chain, line status first
  wire [3:0] id_code  = p_rls  ? uart_fmt_pkg::ID_RLS  :
                        p_rda  ? uart_fmt_pkg::ID_RDA  :
                        p_cti  ? uart_fmt_pkg::ID_CTI  :
                        p_tx_holding_empty_irq ? uart_fmt_pkg::ID_TX_HOLDING_EMPTY_IRQ :
                        p_transmitter_empty_irq ? uart_fmt_pkg::ID_TRANSMITTER_EMPTY_IRQ :
                        p_ms   ? uart_fmt_pkg::ID_MS   : uart_fmt_pkg::ID_NONE;
  // [R4] identity read clears only the reported source; a thr write clears both
  wire       tx_holding_empty_irq_clr = thr_wr || (id_rd && id_code == uart_fmt_pkg::ID_TX_HOLDING_EMPTY_IRQ);
  wire       transmitter_empty_irq_clr = thr_wr || (id_rd && id_code == uart_fmt_pkg::ID_TRANSMITTER_EMPTY_IRQ);
  wire       tx_holding_empty_irq_set = tx_empty && !tx_empty_d_r;
  wire       transmitter_empty_irq_set = tx_done && !transmitter_empty_irq_d_r;
  // [R5] any modem line edge
  wire       ms_set   = modem_lines != modem_d_r;

  // read mux
  wire [7:0] rx_head  = rx_cnt_r != 5'h00 ? rx_mem[rx_rp_r] : 8'h00;
  wire [7:0] ls_val   = {1'b0, tx_done, tx_empty, err_r, rx_cnt_r != 5'h00};
  wire [7:0] rd8      = a_data  ? (divisor_access_select ? div_r[7:0] : rx_head) :
                        a_ier   ? (divisor_access_select ? div_r[15:8] : {3'b000, ier_r}) :
                        a_ident ? {{2{fifo_on_r}}, 2'b00, id_code} :
                        a_fmt   ? frame_r :
                        a_lsr   ? ls_val :
                        a_msr   ? {modem_lines, 3'b000, ms_r} : 8'h00;

  // configuration registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_r   <= uart_fmt_pkg::FMT_RST;
      ier_r     <= uart_fmt_pkg::IER_RST;
      trig_r    <= uart_fmt_pkg::TRIG_RST;
      fifo_on_r <= uart_fmt_pkg::ON_RST;
      div_r     <= uart_fmt_pkg::DIV_RST;
    end else begin
      if (fmt_wr) frame_r <= wdata[7:0];
      if (ier_wr) ier_r <= wdata[4:0];
      if (dll_wr) div_r[7:0] <= wdata[7:0];
      if (dlm_wr) div_r[15:8] <= wdata[7:0];
      // [R7] trigger stored only via enabled write
      if (fs_ok) trig_r <= wdata[uart_fmt_pkg::FS_TRIG +: 2];
      // [R10] writing zero leaves the fifos enabled
      if (fs_ok) fifo_on_r <= 1'b1;
    end
  end

  // storage without reset; pointers guard validity
  always_ff @(posedge sys_clk) begin
    if (rx_push) rx_mem[rx_wp_r] <= rx_word;
    if (tx_push) tx_mem[tx_wp_r] <= wdata[7:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_wp_r  <= 4'h0;
      rx_rp_r  <= 4'h0;
      rx_cnt_r <= 5'h00;
      tx_wp_r  <= 4'h0;
      tx_rp_r  <= 4'h0;
      tx_cnt_r <= 5'h00;
    end else begin
      // [R9] rx pointer reset
      if (rx_flush) begin
        rx_wp_r  <= 4'h0;
        rx_rp_r  <= 4'h0;
        rx_cnt_r <= 5'h00;
      end else begin
        rx_wp_r  <= 4'(rx_wp_r + {3'b000, rx_push});
        rx_rp_r  <= 4'(rx_rp_r + {3'b000, rx_pop});
        rx_cnt_r <= 5'(rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop});
      end
      // [R8] tx pointer reset; a character in flight still finishes
      if (tx_flush) begin
        tx_wp_r  <= 4'h0;
        tx_rp_r  <= 4'h0;
        tx_cnt_r <= 5'h00;
      end else begin
        tx_wp_r  <= 4'(tx_wp_r + {3'b000, tx_push});
        tx_rp_r  <= 4'(tx_rp_r + {3'b000, tx_pop});
        tx_cnt_r <= 5'(tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop});
      end
    end
  end

  // interrupt flags: set beats clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_r        <= 4'h0;
      cti_tmr_r    <= 10'h000;
      cti_r        <= 1'b0;
      tx_holding_empty_irq_r       <= 1'b0;
      transmitter_empty_irq_r       <= 1'b0;
      ms_r         <= 1'b0;
      tx_empty_d_r <= 1'b1;
      transmitter_empty_irq_d_r     <= 1'b1;
      modem_d_r    <= 4'h0;
      irq_r        <= 1'b0;
    end else begin
      // [R1] errors sticky until line status read
      err_r <= (ls_rd ? 4'h0 : err_r) | err_set;
      // [R3] timer restarts on any fifo activity
      if (rx_act) cti_tmr_r <= 10'h000;
      else if (baud_tick && cti_tmr_r != cti_lim) cti_tmr_r <= 10'(cti_tmr_r + 10'h001);
      cti_r <= cti_set || (cti_r && !rb_rd && !rx_flush);
      // [R18] events during an identity read stay pending
      tx_holding_empty_irq_r <= tx_holding_empty_irq_set || (tx_holding_empty_irq_r && !tx_holding_empty_irq_clr);
      transmitter_empty_irq_r <= transmitter_empty_irq_set || (transmitter_empty_irq_r && !transmitter_empty_irq_clr);
      // [R5] cleared by modem status read
      ms_r <= ms_set || (ms_r && !ms_rd);
      tx_empty_d_r <= tx_empty;
      transmitter_empty_irq_d_r     <= tx_done;
      modem_d_r    <= modem_lines;
      // [R17] pending flag is bit 0 inverted
      irq_r <= !id_code[0];
    end
  end

  // transmit serializer
  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_tick_nxt  = tx_tick_r;
    tx_sh_nxt    = tx_sh_r;
    tx_bit_nxt   = tx_bit_r;
    tx_par_nxt   = tx_par_r;
    if (tx_state_r == uart_fmt_pkg::TX_IDLE) begin
      if (tx_pop) begin
        tx_sh_nxt    = tx_mem[tx_rp_r] & wl_mask;
        // [R14] parity always computed; sent (TX_PAR) only when enabled
        tx_par_nxt   = par_calc(tx_mem[tx_rp_r] & wl_mask, ps);
        tx_tick_nxt  = 5'h00;
        tx_state_nxt = uart_fmt_pkg::TX_START;
      end
    end else if (baud_tick) begin
      tx_tick_nxt = 5'(tx_tick_r + 5'h01);
      case (tx_state_r)
        uart_fmt_pkg::TX_START: begin
          if (tx_tick_nxt == uart_fmt_pkg::BIT_TICKS) begin
            tx_tick_nxt  = 5'h00;
            tx_bit_nxt   = 3'h0;
            tx_state_nxt = uart_fmt_pkg::TX_DATA;
          end
        end
        // [R16] 5 to 8 data bits
        uart_fmt_pkg::TX_DATA: begin
          if (tx_tick_nxt == uart_fmt_pkg::BIT_TICKS) begin
            tx_tick_nxt = 5'h00;
            tx_sh_nxt   = {1'b0, tx_sh_r[7:1]};
            tx_bit_nxt  = 3'(tx_bit_r + 3'h1);
            if (tx_bit_r == 3'(3'h4 + {1'b0, wl}))
              tx_state_nxt = pen ? uart_fmt_pkg::TX_PAR : uart_fmt_pkg::TX_STOP;
          end
        end
        uart_fmt_pkg::TX_PAR: begin
          if (tx_tick_nxt == uart_fmt_pkg::BIT_TICKS) begin
            tx_tick_nxt  = 5'h00;
            tx_state_nxt = uart_fmt_pkg::TX_STOP;
          end
        end
        // [R15] stop length in ticks
        uart_fmt_pkg::TX_STOP: begin
          if (tx_tick_nxt == (!stop_bit_select ? uart_fmt_pkg::BIT_TICKS :
              wl == 2'b00 ? uart_fmt_pkg::STOP15_TKS : uart_fmt_pkg::STOP2_TKS)) begin
            tx_tick_nxt  = 5'h00;
            tx_state_nxt = uart_fmt_pkg::TX_IDLE;
          end
        end
        default: tx_state_nxt = uart_fmt_pkg::TX_IDLE;
      endcase
    end
  end

  wire tx_line = tx_state_r == uart_fmt_pkg::TX_START ? 1'b0 :
                 tx_state_r == uart_fmt_pkg::TX_DATA  ? tx_sh_r[0] :
                 tx_state_r == uart_fmt_pkg::TX_PAR   ? tx_par_r : 1'b1;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_r <= uart_fmt_pkg::TX_IDLE;
      tx_tick_r  <= 5'h00;
      tx_sh_r    <= 8'h00;
      tx_bit_r   <= 3'h0;
      tx_par_r   <= 1'b0;
      txd_r      <= 1'b1;
      rdata_r    <= 32'h0000_0000;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_tick_r  <= tx_tick_nxt;
      tx_sh_r    <= tx_sh_nxt;
      tx_bit_r   <= tx_bit_nxt;
      tx_par_r   <= tx_par_nxt;
      // [R12] break overrides the serializer
      txd_r      <= frame_r[uart_fmt_pkg::FF_BRK] ? 1'b0 : tx_line;
      rdata_r    <= rd_en ? {24'h00_0000, rd8} : 32'h0000_0000;
    end
  end

  assign rdata   = rdata_r;
  assign txd     = txd_r;
  assign irq     = irq_r;
  assign divisor = div_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  rls_report_a: assert property ( // [R1]
    (rx_char.valid && rx_char.frame_err && ier_r[uart_fmt_pkg::IE_RLS] && !ier_wr)
      ##1 (!ls_rd && !ier_wr) |-> ##1 irq_r)
    else $error("line status error not reported");
  rls_clear_a: assert property ( // [R1]
    ls_rd && !rx_char.valid |=> err_r == 4'h0)
    else $error("line status read left errors set");
  rda_code_a: assert property ( // [R2]
    ier_r[uart_fmt_pkg::IE_RDA] && rx_cnt_r >= trig_level(trig_r) && err_r == 4'h0
      |-> id_code == uart_fmt_pkg::ID_RDA)
    else $error("data available not reported");
  cti_raise_a: assert property ( // [R3]
    $rose(cti_r) |-> rx_cnt_r != 5'h00 && $past(cti_tmr_r) == 10'(cti_lim - 10'h001))
    else $error("timeout raised at wrong time");
  tx_holding_empty_irq_clear_a: assert property ( // [R4]
    thr_wr && !tx_holding_empty_irq_set |=> !tx_holding_empty_irq_r)
    else $error("thr write did not clear holding empty");
  ms_clear_a: assert property ( // [R5]
    ms_rd && !ms_set |=> !ms_r)
    else $error("modem status read did not clear");
  rx_flush_a: assert property ( // [R9]
    fs_wr && wdata[0] && wdata[1] |=> rx_cnt_r == 5'h00)
    else $error("rx flush ignored");
  tx_flush_a: assert property ( // [R8]
    fs_wr && wdata[0] && wdata[2] |=> tx_cnt_r == 5'h00)
    else $error("tx flush ignored");
  trig_gate_a: assert property ( // [R10]
    fs_wr && !wdata[0] |=> $stable(trig_r) && fifo_on_r)
    else $error("fifo_setup write without bit 0 took effect");
  break_low_a: assert property ( // [R12]
    frame_r[uart_fmt_pkg::FF_BRK] |=> !txd_r)
    else $error("break not forcing line low");
  pend_flag_a: assert property ( // [R17]
    irq_r == $past(p_rls || p_rda || p_cti || p_tx_holding_empty_irq || p_transmitter_empty_irq || p_ms))
    else $error("pending flag mismatch");
  dll_read_a: assert property ( // [R11]
    rd_en && a_data && divisor_access_select |=> rdata_r[7:0] == div_r[7:0])
    else $error("divisor latch not readable");

  cti_seen_c: cover property (p_cti && id_rd);
  rls_seen_c: cover property (p_rls && ls_rd);
  brk_seen_c: cover property (frame_r[uart_fmt_pkg::FF_BRK] ##1 !txd_r);
  transmitter_empty_irq_seen_c: cover property (id_rd && id_code == uart_fmt_pkg::ID_TRANSMITTER_EMPTY_IRQ);

endmodule // uart_irq_fifo_line_format

// ===== verif/line_peer.sv
// remote serial receiver model that samples the transmit line
`timescale 1ns/1ps
module line_peer (
  input  wire logic       sys_clk,
  input  wire logic       baud_tick,
  input  wire logic       txd,
  input  wire logic [3:0] nbits,
  input  wire logic       pen,
  output      logic [7:0] rx_byte,
  output      logic       rx_par,
  output      logic       done
);
  logic       busy_r = 1'b0;
  logic [9:0] tcnt_r = 10'h000;

  // mid-bit sampling, lsb first, parity after data
  always @(posedge sys_clk) begin
    done <= 1'b0;
    if (!busy_r) begin
      if (!txd) begin
        busy_r  <= 1'b1;
        tcnt_r  <= 10'h000;
        rx_byte <= 8'h00;
      end
    end else if (baud_tick) begin
      tcnt_r <= tcnt_r + 10'h001;
      if (tcnt_r[3:0] == 4'h8 && tcnt_r[9:4] != 6'h00) begin
        if (tcnt_r[9:4] <= {2'h0, nbits})
          rx_byte[tcnt_r[6:4] - 3'h1] <= txd;
        else if (pen && tcnt_r[9:4] == {2'h0, nbits} + 6'h01)
          rx_par <= txd;
        else begin
          // low stop bit never reports a character
          busy_r <= 1'b0;
          done   <= txd;
        end
      end
    end
  end
endmodule // line_peer

// ===== verif/uart_irq_fifo_line_format_test.sv
// self-checking bench for the uart irq, fifo and frame format block
`timescale 1ns/1ps
module uart_irq_fifo_line_format_test;
  logic                   sys_clk      = 1'b0;
  logic                   reset_n      = 1'b0;
  logic [7:0]             addr         = 8'h00;
  logic [31:0]            wdata        = 32'h0000_0000;
  logic                   wr_en        = 1'b0;
  logic                   rd_en        = 1'b0;
  logic                   baud_tick    = 1'b0;
  uart_fmt_pkg::rx_char_s rx_char      = '0;
  logic [3:0]             modem_lines  = 4'h0;
  logic [3:0]             nbits        = 4'h8;
  logic                   pen          = 1'b0;
  logic [1:0]             tick_cnt     = 2'h0;
  logic [31:0]            rdata;
  logic [15:0]            divisor;
  logic                   txd;
  logic                   irq;
  logic                   done;
  logic [7:0]             peer_byte;
  logic                   peer_par;
  int                     failures     = 0;
  int                     total_checks = 0;
  int                     cycles       = 0;

  always #12.5 sys_clk = ~sys_clk;

  // baud tick every fourth cycle keeps frames short
  always @(posedge sys_clk) begin
    tick_cnt  <= tick_cnt + 2'h1;
    baud_tick <= (tick_cnt == 2'h3);
    cycles    <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_sim();
    end
  end

  uart_irq_fifo_line_format DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .baud_tick(baud_tick), .rx_char(rx_char),
    .modem_lines(modem_lines), .txd(txd), .irq(irq), .divisor(divisor));

  line_peer peer (
    .sys_clk(sys_clk), .baud_tick(baud_tick), .txd(txd), .nbits(nbits), .pen(pen),
    .rx_byte(peer_byte), .rx_par(peer_par), .done(done));

  task automatic end_sim();
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= {24'h00_0000, d};
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, {24'h00_0000, exp});
  endtask

  task automatic push(input logic [7:0] d, input logic fe);
    @(posedge sys_clk);
    rx_char <= '{valid: 1'b1, data: d, parity: 1'b0, frame_err: fe, brk: 1'b0};
    @(posedge sys_clk);
    rx_char <= '0;
  endtask

  task automatic t_reset_div();
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC1);
    rd_chk(uart_fmt_pkg::OFS_FMT, 8'h00);
    rd_chk(8'h1C, 8'h00);
    wr(uart_fmt_pkg::OFS_FMT, 8'h80);
    wr(uart_fmt_pkg::OFS_DATA, 8'h34);
    wr(uart_fmt_pkg::OFS_IER, 8'h12);
    rd_chk(uart_fmt_pkg::OFS_DATA, 8'h34);
    chk({16'h0000, divisor}, 32'h0000_1234);
    wr(uart_fmt_pkg::OFS_FMT, 8'h03);
    rd_chk(uart_fmt_pkg::OFS_IER, 8'h00);
  endtask

  task automatic t_priority();
    wr(uart_fmt_pkg::OFS_IER, 8'h0D);
    // bit 0 clear: whole write dropped, trigger stays at one
    wr(uart_fmt_pkg::OFS_IDENT, 8'hC6);
    modem_lines <= 4'h5;
    repeat (4) @(posedge sys_clk);
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC0);
    push(8'hA5, 1'b1);
    repeat (4) @(posedge sys_clk);
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC6);
    rd_chk(uart_fmt_pkg::OFS_LSR, 8'h69);
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC4);
    rd_chk(uart_fmt_pkg::OFS_DATA, 8'hA5);
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC0);
    rd_chk(uart_fmt_pkg::OFS_MSR, 8'h51);
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC1);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  task automatic t_trigger();
    int lvl [4] = '{1, 4, 8, 14};
    for (int t = 0; t < 4; t++) begin
      wr(uart_fmt_pkg::OFS_IDENT, {t[1:0], 6'h03});
      for (int n = 1; n < lvl[t]; n++) push(n[7:0], 1'b0);
      repeat (4) @(posedge sys_clk);
      rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC1);
      push(8'h5A, 1'b0);
      repeat (4) @(posedge sys_clk);
      rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC4);
    end
    wr(uart_fmt_pkg::OFS_IER, 8'h00);
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC1);
    wr(uart_fmt_pkg::OFS_IDENT, 8'h07);
    rd_chk(uart_fmt_pkg::OFS_LSR, 8'h60);
  endtask

  task automatic t_timeout();
    wr(uart_fmt_pkg::OFS_IER, 8'h01);
    wr(uart_fmt_pkg::OFS_IDENT, 8'h43);
    push(8'h11, 1'b0);
    // 500 ticks is under 3.5 frames of ten bits
    repeat (2000) @(posedge sys_clk);
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC1);
    // still inside 4.5 frames, so late timeouts also show
    repeat (800) @(posedge sys_clk);
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hCC);
    rd_chk(uart_fmt_pkg::OFS_DATA, 8'h11);
    rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC1);
  endtask

  task automatic t_transmit();
    logic [7:0] fmt [5] = '{8'h0B, 8'h1A, 8'h29, 8'h3C, 8'h07};
    logic [7:0] d;
    logic [7:0] m;
    logic       ep;
    int         k;
    wr(uart_fmt_pkg::OFS_IER, 8'h12);
    for (int i = 0; i < 5; i++) begin
      d  = 8'h96 + i[7:0];
      m  = 8'hFF >> (2'h3 - fmt[i][1:0]);
      ep = fmt[i][5] ? ~fmt[i][4] : (^(d & m) ^ ~fmt[i][4]);
      wr(uart_fmt_pkg::OFS_FMT, fmt[i]);
      nbits <= {2'h0, fmt[i][1:0]} + 4'h5;
      pen   <= fmt[i][3];
      wr(uart_fmt_pkg::OFS_DATA, d);
      if (i == 0) begin
        repeat (4) @(posedge sys_clk);
        rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC2);
        rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC1);
      end
      k = 0;
      while (done !== 1'b1 && k < 2000) begin
        @(posedge sys_clk);
        #1;
        k++;
      end
      chk({31'h0, done}, 32'h0000_0001);
      chk({24'h00_0000, peer_byte}, {24'h00_0000, d & m});
      if (fmt[i][3])
        chk({31'h0, peer_par}, {31'h0, ep});
      if (i == 0) begin
        repeat (200) @(posedge sys_clk);
        rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hCE);
        rd_chk(uart_fmt_pkg::OFS_IDENT, 8'hC1);
      end
    end
    wr(uart_fmt_pkg::OFS_FMT, 8'h43);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({31'h0, txd}, 32'h0000_0000);
    wr(uart_fmt_pkg::OFS_FMT, 8'h03);
    repeat (3) @(posedge sys_clk);
    #1;
    chk({31'h0, txd}, 32'h0000_0001);
  endtask

  task automatic t_rx_check();
    // same odd-weight byte, received parity 0, checked only with parity on
    wr(uart_fmt_pkg::OFS_IDENT, 8'h03);
    repeat (200) @(posedge sys_clk);
    push(8'h07, 1'b0);
    rd_chk(uart_fmt_pkg::OFS_LSR, 8'h61);
    wr(uart_fmt_pkg::OFS_FMT, 8'h1B);
    push(8'h07, 1'b0);
    rd_chk(uart_fmt_pkg::OFS_LSR, 8'h65);
    rd_chk(uart_fmt_pkg::OFS_LSR, 8'h61);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset_div();
    t_priority();
    t_trigger();
    t_timeout();
    t_transmit();
    t_rx_check();
    end_sim();
  end
endmodule // uart_irq_fifo_line_format_test
